// >>> hw/smsp_pkg.sv
// Shared constants and types of the supply monitor status block.
package smsp_pkg;

	// ==========================================================
	// Register map
	// The control/status register sits at the first word.
	localparam logic [31:0] CSR_ADDR  = 32'h0000_0000;
	localparam logic [7:0]  CSR_RESET = 8'h00;

	// ==========================================================
	// Field positions of the control/status register
	localparam int SEL_POS  = 7;
	localparam int IE_POS   = 6;
	localparam int FLAG_POS = 5;
	localparam int UV_POS   = 4;
	localparam int WD_POS   = 0;

	// ==========================================================
	// Reset delay, in CPU cycles, chosen by the option strap
	localparam int DLY_SHORT_CYC = 256;
	localparam int DLY_LONG_CYC  = 4096;
	localparam int CNT_W         = 12;

	// ==========================================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ==========================================================
	// Start-up sequence states, Gray coded
	typedef enum logic [1:0] {
		SMSP_DELAY = 2'h0,
		SMSP_RUN   = 2'h1
	} smsp_start_t;

endpackage : smsp_pkg

// >>> hw/smsp_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
`timescale 1ns/1ps
`default_nettype none
module smsp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d_async,
	output logic      [W-1:0] q
);

	// ==========================================================
	// Metastability guard
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// The first stage feeds the second stage and nothing else.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= d_async;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule : smsp_sync
`default_nettype wire

// >>> hw/smsp_cause.sv
// Reset-cause flags kept across bus resets; power-on clears both, an undervolt reset clears the watchdog flag.
`timescale 1ns/1ps
`default_nettype none
module smsp_cause (
	input  wire logic hclk,
	input  wire logic por_n,
	input  wire logic uv_rst_async,
	input  wire logic wd_rst_async,
	input  wire logic clr_uv,
	input  wire logic clr_wd,
	output logic      uv_flag,
	output logic      wd_flag
);

	// ==========================================================
	// Reset source levels
	logic [1:0] src_s;
	logic       uv_ff;
	logic       wd_ff;

	// The reset sources come from the reset manager, not this clock.
	smsp_sync #(
		.W(2)
	) u_src_sync (
		.clk    (hclk),
		.rst_n  (por_n),
		.d_async({wd_rst_async, uv_rst_async}),
		.q      (src_s)
	);

	// ==========================================================
	// Flags
	// Of the resets only power-on clears the undervolt flag, so the original cause survives.
	// RULE13 RULE14 undervolt flag
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			uv_ff <= 1'b0;
		end else if (src_s[0]) begin
			uv_ff <= 1'b1;
		end else if (clr_uv) begin
			uv_ff <= 1'b0;
		end
	end

	// An undervolt reset wipes the watchdog cause, so it always wins.
	// RULE15 RULE16 watchdog flag
	always_ff @(posedge hclk or negedge por_n) begin
		if (!por_n) begin
			wd_ff <= 1'b0;
		end else if (src_s[0]) begin
			wd_ff <= 1'b0;
		end else if (src_s[1]) begin
			wd_ff <= 1'b1;
		end else if (clr_wd) begin
			wd_ff <= 1'b0;
		end
	end

	assign uv_flag = uv_ff;
	assign wd_flag = wd_ff;

	// ==========================================================
	// Checks
	a_uv_sets_flag: // RULE13
	assert property (@(posedge hclk) disable iff (!por_n)
		src_s[0] |=> uv_ff && !wd_ff)
		else $error("undervolt reset did not set its flag");

	a_wd_keeps_uv: // RULE14
	assert property (@(posedge hclk) disable iff (!por_n)
		uv_ff && !clr_uv |=> uv_ff)
		else $error("undervolt flag lost without a clear");

endmodule : smsp_cause
`default_nettype wire

// >>> hw/smsp_top.sv
// Supply monitor status block: warning detector and reset causes.
// Notes on behaviour
// RULE1 - Select bit clear: the detector watches the main supply.
// RULE2 - Select bit set: watch the sense pin, events on both edges.
// RULE3 - With enable set, every flag change raises an interrupt request.
// RULE4 - Warning flag is read-only; 0 above upper, 1 below lower threshold.
// RULE5 - Pending request clears when the CPU enters the service routine.
// RULE6 - No interrupt for a rise completed inside the reset delay.
// RULE7 - Slow rise, enabled early: interrupt on enable and on crossing.
// RULE8 - Slow rise, enabled after crossing: exactly one interrupt.
// RULE9 - Wait mode changes nothing; an enabled warning wakes the CPU.
// RULE10 - Halt freezes the register; warnings never wake from halt.
// RULE11 - Register resets to zero except the two reset-cause flags.
// RULE12 - Detector works only when the undervoltage detector is enabled.
// RULE13 - Undervolt flag set by undervolt reset, cleared by writing zero.
// RULE14 - Undervolt flag survives external and watchdog resets.
// RULE15 - Watchdog flag set by watchdog reset; cleared by zero or undervolt.
// RULE16 - Flag pair encodes cause: pin, watchdog, or undervolt.
// RULE17 - Software ignores undervolt flag when the detector is disabled.
// RULE18 - Software writes the reserved bits as zero.
// RULE19 - Warning flag follows the comparator output in real time.
// RULE20 - Comparator outputs are synchronised before any use.
`timescale 1ns/1ps
`default_nettype none
module smsp_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        por_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        supply_cmp_async,
	input  wire logic        sense_cmp_async,
	input  wire logic        detector_en_async,
	input  wire logic        long_delay_async,
	input  wire logic        undervolt_rst_async,
	input  wire logic        watchdog_rst_async,
	input  wire logic        cpu_wait,
	input  wire logic        cpu_halt,
	input  wire logic        irq_ack,
	output logic             warn_irq,
	output logic             wake_req
);

	// ==========================================================
	// Declarations
	logic [3:0]               pins_s;
	logic                     supply_s;
	logic                     sense_s;
	logic                     det_en_s;
	logic                     long_s;
	logic                     mon_sel;
	logic                     nxt_flag;
	logic                     toggle;
	logic                     ie_rise;
	logic                     pend_set;
	logic [7:0]               csr_val;
	logic                     uv_flag;
	logic                     wd_flag;
	logic                     clr_uv;
	logic                     clr_wd;
	logic                     addr_ok;
	logic                     addr_hit;
	logic [smsp_pkg::CNT_W-1:0] dly_lim;
	smsp_pkg::smsp_start_t    st_ff;
	smsp_pkg::smsp_start_t    nxt_st;
	logic [smsp_pkg::CNT_W-1:0] cnt_ff;
	logic                     sel_ff;
	logic                     ie_ff;
	logic                     flag_ff;
	logic                     pend_ff;
	logic                     wr_ff;
	logic                     hit_ff;
	logic [31:0]              hrdata_ff;
	logic                     hready_ff;
	logic                     hresp_ff;
	logic                     irq_ff;
	logic                     wake_ff;

	// ==========================================================
	// Input synchronisation
	// Comparators and straps are analog or strap levels from outside.
	// RULE20 sync comparator levels
	smsp_sync #(
		.W(4)
	) u_pin_sync (
		.clk    (hclk),
		.rst_n  (hresetn),
		.d_async({long_delay_async, detector_en_async,
			sense_cmp_async, supply_cmp_async}),
		.q      (pins_s)
	);

	assign supply_s = pins_s[0];
	assign sense_s  = pins_s[1];
	assign det_en_s = pins_s[2];
	assign long_s   = pins_s[3];

	// ==========================================================
	// Reset-cause flags
	// These live in the power-on domain and outlast bus resets.
	smsp_cause u_cause (
		.hclk        (hclk),
		.por_n       (por_n),
		.uv_rst_async(undervolt_rst_async),
		.wd_rst_async(watchdog_rst_async),
		.clr_uv      (clr_uv),
		.clr_wd      (clr_wd),
		.uv_flag     (uv_flag),
		.wd_flag     (wd_flag)
	);

	// ==========================================================
	// Bus slave
	// A NONSEQ transfer is taken when this slave is selected and the bus ready.
	assign addr_ok  = hsel && hready && (htrans == smsp_pkg::HTRANS_NONSEQ);
	assign addr_hit = (haddr == smsp_pkg::CSR_ADDR);

	// Writes land in the data phase, which is when hwdata stands.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_ff  <= 1'b0;
			hit_ff <= 1'b0;
		end else begin
			wr_ff  <= addr_ok && hwrite;
			hit_ff <= addr_hit;
		end
	end

	// Reads answer with zero wait states; unmapped words read zero.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata_ff <= addr_hit ? {24'h00_0000, csr_val} : 32'h0000_0000;
		end
	end

	// The slave never stretches a transfer and always answers OKAY.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hready_ff <= 1'b1;
			hresp_ff  <= 1'b0;
		end else begin
			hready_ff <= 1'b1;
			hresp_ff  <= 1'b0;
		end
	end

	// Reserved bits always read as zero.
	// RULE4 RULE16 read layout
	always_comb begin
		csr_val                     = smsp_pkg::CSR_RESET;
		csr_val[smsp_pkg::SEL_POS]  = sel_ff;
		csr_val[smsp_pkg::IE_POS]   = ie_ff;
		csr_val[smsp_pkg::FLAG_POS] = flag_ff;
		csr_val[smsp_pkg::UV_POS]   = uv_flag;
		csr_val[smsp_pkg::WD_POS]   = wd_flag;
	end

	// A zero written to a cause flag clears it; halt blocks writes.
	// RULE13 RULE15 write zero
	assign clr_uv = wr_ff && hit_ff && !cpu_halt && !hwdata[smsp_pkg::UV_POS];
	assign clr_wd = wr_ff && hit_ff && !cpu_halt && !hwdata[smsp_pkg::WD_POS];

	// ==========================================================
	// Control bits
	// Halt freezes the register, so writes are dropped meanwhile.
	// RULE1 RULE10 RULE11 control write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_ff <= 1'b0;
			ie_ff  <= 1'b0;
		end else if (wr_ff && hit_ff && !cpu_halt) begin
			sel_ff <= hwdata[smsp_pkg::SEL_POS];
			ie_ff  <= hwdata[smsp_pkg::IE_POS];
		end
	end

	// ==========================================================
	// Start-up delay
	// While the reset delay runs, crossings are tracked but not
	// reported; a fast supply rise thus raises no warning.
	assign dly_lim = long_s ? smsp_pkg::CNT_W'(smsp_pkg::DLY_LONG_CYC - 1)
		: smsp_pkg::CNT_W'(smsp_pkg::DLY_SHORT_CYC - 1);

	always_comb begin
		case (st_ff)
			smsp_pkg::SMSP_DELAY: begin
				nxt_st = (cnt_ff == dly_lim) ? smsp_pkg::SMSP_RUN
					: smsp_pkg::SMSP_DELAY;
			end
			smsp_pkg::SMSP_RUN: begin
				nxt_st = smsp_pkg::SMSP_RUN;
			end
			default: begin
				nxt_st = smsp_pkg::SMSP_DELAY;
			end
		endcase
	end

	// RULE6 delay counter
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_ff  <= smsp_pkg::SMSP_DELAY;
			cnt_ff <= '0;
		end else begin
			st_ff <= nxt_st;
			if (st_ff == smsp_pkg::SMSP_DELAY) begin
				cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	// ==========================================================
	// Warning flag
	// The detector is dead without the undervoltage detector, so the
	// flag then rests at zero.
	// RULE1 RULE2 RULE12 source select
	assign mon_sel  = sel_ff ? sense_s : supply_s;
	assign nxt_flag = det_en_s && mon_sel;

	// RULE4 RULE19 live flag
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flag_ff <= 1'b0;
		end else if (!cpu_halt) begin
			flag_ff <= nxt_flag;
		end
	end

	// ==========================================================
	// Interrupt request
	// Both directions count, and only once the delay is over.
	// RULE2 RULE3 RULE6 edge events
	assign toggle = (nxt_flag != flag_ff) && !cpu_halt
		&& (st_ff == smsp_pkg::SMSP_RUN);

	// Enabling while below the threshold reports the present state.
	// RULE7 RULE8 enable event
	assign ie_rise = wr_ff && hit_ff && !cpu_halt && !ie_ff
		&& hwdata[smsp_pkg::IE_POS] && flag_ff;

	// Changes latch even while disabled, so enabling after a slow
	// crossing still delivers that one late request.
	// RULE3 RULE8 latch every change
	assign pend_set = toggle || ie_rise;

	// A new event in the acknowledge cycle is kept, not lost.
	// RULE5 auto clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_ff <= 1'b0;
		end else if (pend_set) begin
			pend_ff <= 1'b1;
		end else if (irq_ack) begin
			pend_ff <= 1'b0;
		end
	end

	// Halt never hears a warning; wait does.
	// RULE9 RULE10 wake logic
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_ff  <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			irq_ff  <= pend_ff && ie_ff;
			wake_ff <= pend_ff && ie_ff && cpu_wait && !cpu_halt;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout = hready_ff;
	assign hresp     = hresp_ff;
	assign hrdata    = hrdata_ff;
	assign warn_irq  = irq_ff;
	assign wake_req  = wake_ff;

	// ==========================================================
	// Checks
	a_flag_follows: // RULE19
	assert property (@(posedge hclk) disable iff (!hresetn)
		!cpu_halt && det_en_s |=> flag_ff == $past(mon_sel))
		else $error("warning flag does not follow comparator");

	a_detector_off: // RULE12
	assert property (@(posedge hclk) disable iff (!hresetn)
		!cpu_halt && !det_en_s |=> !flag_ff)
		else $error("flag set while detector disabled");

	a_halt_frozen: // RULE10
	assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_halt |=> $stable(flag_ff) && $stable(sel_ff) && $stable(ie_ff))
		else $error("register changed during halt");

	a_toggle_irq: // RULE3
	assert property (@(posedge hclk) disable iff (!hresetn)
		toggle && ie_ff |=> pend_ff ##1 irq_ff)
		else $error("flag change raised no request");

	a_ack_clears: // RULE5
	assert property (@(posedge hclk) disable iff (!hresetn)
		irq_ack && !pend_set |=> !pend_ff ##1 !irq_ff)
		else $error("acknowledge left request pending");

	a_delay_quiet: // RULE6
	assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff == smsp_pkg::SMSP_DELAY && !ie_rise && !pend_ff |=> !pend_ff)
		else $error("request raised inside reset delay");

	a_enable_event: // RULE7
	assert property (@(posedge hclk) disable iff (!hresetn)
		ie_rise |=> pend_ff && ie_ff ##1 irq_ff)
		else $error("enable while below raised no request");

	a_halt_no_wake: // RULE10
	assert property (@(posedge hclk) disable iff (!hresetn)
		cpu_halt |=> !wake_ff)
		else $error("warning woke the device from halt");

	a_wait_wakes: // RULE9
	assert property (@(posedge hclk) disable iff (!hresetn)
		pend_ff && ie_ff && cpu_wait && !cpu_halt |=> wake_ff && irq_ff)
		else $error("enabled warning did not wake from wait");

	a_delay_ends: // RULE6
	assert property (@(posedge hclk) disable iff (!hresetn)
		st_ff == smsp_pkg::SMSP_DELAY && cnt_ff == dly_lim
		|=> st_ff == smsp_pkg::SMSP_RUN)
		else $error("reset delay did not end on count");

endmodule : smsp_top
`default_nettype wire

// >>> tb/smsp_far.sv
// Model of the analog comparators and of the CPU that services the warning.
`timescale 1ns/1ps
`default_nettype none
module smsp_far (
	input  wire logic       hclk,
	input  wire logic       sup_lvl,
	input  wire logic       sen_lvl,
	input  wire logic [3:0] ack_dly,
	input  wire logic       warn_irq,
	output logic            supply_cmp_async,
	output logic            sense_cmp_async,
	output logic            irq_ack
);
	// ==========================================================
	// Comparators
	// Outputs move off the clock grid, as an analog edge would.
	initial begin
		supply_cmp_async = 1'b0;
		sense_cmp_async = 1'b0;
	end
	always @(sup_lvl) begin
		supply_cmp_async <= #37 sup_lvl;
	end
	always @(sen_lvl) begin
		sense_cmp_async <= #53 sen_lvl;
	end

	// ==========================================================
	// CPU entry into the service routine
	// The latency is set by the bench, so both prompt and slow entry occur.
	// entry acknowledge pulse
	initial begin
		irq_ack = 1'b0;
		forever begin
			@(posedge hclk);
			if (warn_irq === 1'b1) begin
				repeat (ack_dly) @(posedge hclk);
				irq_ack <= 1'b1;
				@(posedge hclk);
				irq_ack <= 1'b0;
				repeat (3) @(posedge hclk);
			end
		end
	end
endmodule : smsp_far
`default_nettype wire

// >>> tb/supply_monitor_status_tb.sv
// Self-checking bench of the supply monitor status block.
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_status_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        por_n = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        det_en = 1'b1;
	logic        long_dly = 1'b0;
	logic        uv_rst = 1'b0;
	logic        wd_rst = 1'b0;
	logic        cpu_wait = 1'b0;
	logic        cpu_halt = 1'b0;
	logic        sup_lvl = 1'b0;
	logic        sen_lvl = 1'b0;
	logic [3:0]  ack_dly = 4'h1;
	wire logic   hreadyout, hresp, warn_irq, wake_req, sup_cmp, sen_cmp, irq_ack;
	wire logic [31:0] hrdata;
	int          error_cnt = 0, cmp_count = 0, cyc = 0, seed = 3, irq_cnt = 0, exp_irq = 0;
	logic        irq_q = 1'b0;
	int          wake_cnt = 0, wake_base = 0;
	logic        m_sel, m_ie, m_flag, m_uv, m_wd, m_det, m_pend;
	logic [31:0] rd, rnd;

	smsp_top DUT (.hclk(hclk), .hresetn(hresetn), .por_n(por_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .supply_cmp_async(sup_cmp), .sense_cmp_async(sen_cmp),
		.detector_en_async(det_en), .long_delay_async(long_dly),
		.undervolt_rst_async(uv_rst), .watchdog_rst_async(wd_rst), .cpu_wait(cpu_wait),
		.cpu_halt(cpu_halt), .irq_ack(irq_ack), .warn_irq(warn_irq), .wake_req(wake_req));

	smsp_far u_far (.hclk(hclk), .sup_lvl(sup_lvl), .sen_lvl(sen_lvl), .ack_dly(ack_dly),
		.warn_irq(warn_irq), .supply_cmp_async(sup_cmp), .sense_cmp_async(sen_cmp),
		.irq_ack(irq_ack));

	// ==========================================================
	// Clock, request counter and hang guard
	initial begin
		forever #50 hclk = ~hclk;
	end
	// Requests are counted on rising edges, so a request held long counts once.
	always @(posedge hclk) begin
		irq_q <= warn_irq;
		if (warn_irq === 1'b1 && irq_q !== 1'b1) irq_cnt++;
		if (wake_req === 1'b1) wake_cnt++;
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end

	// ==========================================================
	// Checking and bus tasks
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// One single transfer; called just after a rising edge.
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= smsp_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask : ahb

	function automatic logic [31:0] mcsr();
		return {24'h0, m_sel, m_ie, m_flag, m_uv, 3'h0, m_wd};
	endfunction : mcsr

	// Model: a flag change with the enable set owes one request.
	task automatic upd();
		logic nf;
		nf = m_det & (m_sel ? sen_lvl : sup_lvl);
		if (nf !== m_flag && m_ie) exp_irq++;
		else if (nf !== m_flag) m_pend = 1'b1;
		m_flag = nf;
	endtask : upd

	task automatic rd_chk();
		ahb(1'b0, smsp_pkg::CSR_ADDR, 32'h0, rd);
		chk("csr", mcsr(), rd);
	endtask : rd_chk

	// Reserved bits 3:1 always go out as zero.
	task automatic wr(input logic [7:0] v);
		ahb(1'b1, smsp_pkg::CSR_ADDR, {24'h0, v & 8'hF1}, rd);
		if (!m_ie && v[6] && (m_flag || m_pend)) exp_irq++;
		if (v[6]) m_pend = 1'b0;
		m_sel = v[7];
		m_ie = v[6];
		if (!v[4]) m_uv = 1'b0;
		if (!v[0]) m_wd = 1'b0;
		repeat (20) @(posedge hclk);
		upd();
	endtask : wr

	task automatic set_cmp(input logic s, input logic e);
		sup_lvl <= s;
		sen_lvl <= e;
		repeat (20) @(posedge hclk);
		upd();
		chk("irq count", exp_irq, irq_cnt);
	endtask : set_cmp

	// A chip reset, optionally caused by undervoltage or the watchdog.
	task automatic do_rst(input logic uv, input logic wd, input int n);
		hresetn <= 1'b0;
		uv_rst <= uv;
		wd_rst <= wd;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		uv_rst <= 1'b0;
		wd_rst <= 1'b0;
		if (uv) begin
			m_uv = 1'b1;
			m_wd = 1'b0;
		end else if (wd) begin
			m_wd = 1'b1;
		end
		m_sel = 1'b0;
		m_ie = 1'b0;
		m_flag = m_det & sup_lvl;
		m_pend = 1'b0;
		repeat (n) @(posedge hclk);
	endtask : do_rst

	// ==========================================================
	// Main sequence
	initial begin
		{m_sel, m_ie, m_flag, m_uv, m_wd, m_pend} = 6'h00;
		m_det = 1'b1;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		por_n <= 1'b1;
		repeat (270) @(posedge hclk);
		rd_chk();
		ahb(1'b0, 32'h0000_0010, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk("hready", 32'h1, {31'h0, hreadyout});
		$display("test reset values done");
		// A rise completed inside the start-up delay raises nothing.
		do_rst(1'b0, 1'b0, 0);
		wr(8'h40);
		sup_lvl <= 1'b1;
		repeat (10) @(posedge hclk);
		sup_lvl <= 1'b0;
		repeat (300) @(posedge hclk);
		chk("irq count", exp_irq, irq_cnt);
		$display("test start-up delay done");
		ack_dly <= 4'h6;
		wr(8'h00);
		set_cmp(1'b1, 1'b0);
		wr(8'h40);
		set_cmp(1'b0, 1'b0);
		chk("two requests", 32'h2, irq_cnt);
		ack_dly <= 4'h1;
		wr(8'h00);
		set_cmp(1'b1, 1'b0);
		set_cmp(1'b0, 1'b0);
		wr(8'h40);
		chk("one request", 32'h3, irq_cnt);
		$display("test slow rise done");
		for (int i = 0; i < 12; i++) begin
			rnd = $random(seed);
			wr({rnd[0], 7'h00});
			wr({rnd[0], 7'h40});
			set_cmp(rnd[1], rnd[2]);
			rd_chk();
		end
		wr(8'hE0);
		ahb(1'b0, smsp_pkg::CSR_ADDR, 32'h0, rd);
		chk("flag read-only", {31'h0, m_flag}, {31'h0, rd[smsp_pkg::FLAG_POS]});
		rd_chk();
		$display("test random toggles done");
		wr(8'h40);
		cpu_wait <= 1'b1;
		wake_base = wake_cnt;
		set_cmp(~sup_lvl, sen_lvl);
		chk("wake", 32'h1, {31'h0, wake_cnt > wake_base});
		cpu_wait <= 1'b0;
		cpu_halt <= 1'b1;
		repeat (2) @(posedge hclk);
		wake_base = wake_cnt;
		ahb(1'b1, smsp_pkg::CSR_ADDR, 32'h0000_0080, rd);
		sup_lvl <= ~sup_lvl;
		repeat (20) @(posedge hclk);
		rd_chk();
		chk("halt irq", exp_irq, irq_cnt);
		chk("halt wake", 32'h0, {31'h0, wake_cnt > wake_base});
		sup_lvl <= ~sup_lvl;
		repeat (20) @(posedge hclk);
		cpu_halt <= 1'b0;
		$display("test wait and halt done");
		wr(8'h00);
		det_en <= 1'b0;
		m_det = 1'b0;
		set_cmp(1'b1, 1'b1);
		ahb(1'b0, smsp_pkg::CSR_ADDR, 32'h0, rd);
		chk("flag disabled", 32'h0, {31'h0, rd[5]});
		det_en <= 1'b1;
		m_det = 1'b1;
		set_cmp(1'b0, 1'b0);
		$display("test detector disabled done");
		// The long start-up delay keeps a crossing made just after reset quiet through 1000 cycles.
		long_dly <= 1'b1;
		do_rst(1'b0, 1'b0, 0);
		wr(8'h40);
		sup_lvl <= 1'b1;
		repeat (1000) @(posedge hclk);
		chk("long delay quiet", exp_irq, irq_cnt);
		m_flag = 1'b1;
		repeat (3100) @(posedge hclk);
		set_cmp(1'b0, 1'b0);
		long_dly <= 1'b0;
		$display("test long delay done");
		do_rst(1'b1, 1'b0, 270);
		rd_chk();
		do_rst(1'b0, 1'b1, 270);
		rd_chk();
		do_rst(1'b0, 1'b0, 270);
		rd_chk();
		wr(8'h10);
		rd_chk();
		do_rst(1'b0, 1'b1, 270);
		wr(8'h01);
		rd_chk();
		do_rst(1'b1, 1'b0, 270);
		rd_chk();
		$display("test reset causes done");
		print_verdict();
	end
endmodule : supply_monitor_status_tb
`default_nettype wire
